// ### rtl/atp_pkg.sv
// constants and types shared by the polarity and flag transmitter block
package atp_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BAUD_CTRL_OFS = 8'h04;
    localparam logic [7:0] DIV_OFS = 8'h08;
    localparam logic [7:0] HOLD_OFS = 8'h0C;
    localparam logic [7:0] FLAG_OFS = 8'h10;
    localparam logic [7:0] IEN_OFS = 8'h14;
    localparam logic [7:0] EVT_OFS = 8'h18;
    localparam logic [7:0] MASK_OFS = 8'h1C;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int CTRL_NINE_BIT = 2;
    localparam int POL_BIT = 0;
    localparam int FLAG_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int FULL_BIT = 2;
    localparam int IEN_BIT = 0;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_EMPTY_BIT = 1;
    // widths
    localparam int CTRL_W = 3;
    localparam int DIV_W = 16;
    localparam int DATA_W = 9;
    localparam int EVT_W = 2;
    localparam int CNT_W = 4;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 16'h00D8;
    localparam logic [DATA_W-1:0] HOLD_RST = 9'h000;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
    // bits left after the start bit: data plus one stop bit
    localparam logic [CNT_W-1:0] REM8_BITS = 4'h9;
    localparam logic [CNT_W-1:0] REM9_BITS = 4'hA;
    // cycles from a buffer change to a valid flag
    localparam int FLAG_DELAY_CYC = 2;
    // shifter state
    typedef enum logic {ST_IDLE, ST_SHIFT} atp_tx_state_t;
endpackage : atp_pkg

// ### rtl/atp_baud_gen.sv
// bit period tick generator for the transmitter
`timescale 1ns/1ps
module atp_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic restart,
    input wire logic [atp_pkg::DIV_W-1:0] div,
    output logic tick
);
    import atp_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;

    // restart aligns the first bit period with the start bit
    always_comb
    begin
        tick = run && (cnt_reg == div);
        if (restart || !run || tick)
            cnt_next = '0;
        else
            cnt_next = cnt_reg + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule : atp_baud_gen

// ### rtl/atp_tx_shifter.sv
// transmit shift register sending one framed character
`timescale 1ns/1ps
module atp_tx_shifter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [atp_pkg::DATA_W-1:0] data,
    input wire logic nine,
    input wire logic tick,
    output logic line_raw,
    output logic busy,
    output logic done
);
    import atp_pkg::*;

    atp_tx_state_t state_reg;
    atp_tx_state_t state_next;
    logic [DATA_W:0] sh_reg;
    logic [DATA_W:0] sh_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic line_reg;
    logic line_next;

    // frame sequencing, one bit per tick
    always_comb
    begin
        state_next = state_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        line_next = line_reg;
        done = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                line_next = 1'b1;
                if (load)
                begin
                    line_next = 1'b0;
                    // unused ninth bit acts as the stop mark in 8 bit mode
                    sh_next = {1'b1, nine ? data[8] : 1'b1, data[7:0]};
                    cnt_next = nine ? REM9_BITS : REM8_BITS;
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (tick)
                begin
                    if (cnt_reg == '0)
                    begin
                        // stop bit done, line rests at mark
                        line_next = 1'b1;
                        done = 1'b1;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        line_next = sh_reg[0];
                        sh_next = {1'b1, sh_reg[DATA_W:1]};
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            sh_reg <= '1;
            cnt_reg <= '0;
            line_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            line_reg <= line_next;
        end
    end

    // helper: first data bit expected after each start bit
    logic first_pend_reg;
    logic first_pend_next;
    logic exp_lsb_reg;
    logic exp_lsb_next;
    always_comb
    begin
        first_pend_next = first_pend_reg;
        exp_lsb_next = exp_lsb_reg;
        if (load)
        begin
            first_pend_next = 1'b1;
            exp_lsb_next = data[0];
        end
        else if (tick)
            first_pend_next = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_pend_reg <= 1'b0;
            exp_lsb_reg <= 1'b0;
        end
        else
        begin
            first_pend_reg <= first_pend_next;
            exp_lsb_reg <= exp_lsb_next;
        end
    end

    // the bit after the start bit is the lsb
    lsb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (first_pend_reg && tick) |=> line_raw == exp_lsb_reg)
        else $error("first data bit not the lsb");

    assign line_raw = line_reg;
    assign busy = (state_reg == ST_SHIFT);
endmodule : atp_tx_shifter

// ### rtl/atp_tx_top.sv
// apb transmitter with output polarity control and buffer-empty flag
// Behaviour
// - polarity bit resets zero, line high-true
// - polarity bit one inverts idle and data
// - inversion applies in asynchronous mode only
// - flag set when enabled and buffer empty
// - flag clear only when disabled or character queued
// - flag valid three cycles after buffer write
// - flag read-only, writes ignored
// - flag interrupt needs enable; flag sets regardless
// - start bit, eight/nine data, stop bit
// - data bits least significant first
// - queued character waits for previous stop bit
// - enabling transmitter sets the flag
`timescale 1ns/1ps
module atp_tx_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_line,
    output logic irq
);
    import atp_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic tx_polarity_invert_reg;
    logic tx_polarity_invert_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [DATA_W-1:0] tx_holding_buffer_reg;
    logic [DATA_W-1:0] tx_holding_buffer_next;
    logic hold_full_reg;
    logic hold_full_next;
    logic tx_interrupt_enable_reg;
    logic tx_interrupt_enable_next;
    logic [EVT_W-1:0] evt_reg;
    logic [EVT_W-1:0] evt_next;
    logic [EVT_W-1:0] mask_reg;
    logic [EVT_W-1:0] mask_next;
    logic cond_d1_reg;
    logic cond_d1_next;
    logic tx_buffer_empty_flag_reg;
    logic tx_buffer_empty_flag_next;
    logic tx_line_reg;
    logic tx_line_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic acc;
    logic wr;
    logic rd_setup;
    logic hit;
    logic en;
    logic sync_mode;
    logic tx_run;
    logic load;
    logic busy;
    logic done;
    logic line_raw;
    logic tick;
    logic empty_cond;

    // apb decode; every register answers without wait states
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb
    begin
        unique case (paddr)
            CTRL_OFS, BAUD_CTRL_OFS, DIV_OFS, HOLD_OFS,
            FLAG_OFS, IEN_OFS, EVT_OFS, MASK_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    assign en = ctrl_reg[CTRL_EN_BIT];
    assign sync_mode = ctrl_reg[CTRL_SYNC_BIT];
    // clocked mode is not built here, so the async engine loads no new character in it; a frame under way still finishes
    assign tx_run = en && !sync_mode;
    // queued character moves only once shifter is free
    assign load = tx_run && hold_full_reg && !busy;

    // software-written control registers
    always_comb
    begin
        ctrl_next = ctrl_reg;
        tx_polarity_invert_next = tx_polarity_invert_reg;
        div_next = div_reg;
        tx_interrupt_enable_next = tx_interrupt_enable_reg;
        mask_next = mask_reg;
        if (wr)
        begin
            unique case (paddr)
                CTRL_OFS: ctrl_next = pwdata[CTRL_W-1:0];
                BAUD_CTRL_OFS: tx_polarity_invert_next = pwdata[POL_BIT];
                DIV_OFS: div_next = pwdata[DIV_W-1:0];
                IEN_OFS: tx_interrupt_enable_next = pwdata[IEN_BIT];
                MASK_OFS: mask_next = pwdata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RST;
            tx_polarity_invert_reg <= 1'b0;
            div_reg <= DIV_RST;
            tx_interrupt_enable_reg <= 1'b0;
            mask_reg <= EVT_RST;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            tx_polarity_invert_reg <= tx_polarity_invert_next;
            div_reg <= div_next;
            tx_interrupt_enable_reg <= tx_interrupt_enable_next;
            mask_reg <= mask_next;
        end
    end

    // holding buffer; a write in the load cycle stays queued behind it
    always_comb
    begin
        tx_holding_buffer_next = tx_holding_buffer_reg;
        hold_full_next = hold_full_reg;
        if (load)
            hold_full_next = 1'b0;
        if (!en)
            hold_full_next = 1'b0;
        if (wr && paddr == HOLD_OFS)
        begin
            tx_holding_buffer_next = pwdata[DATA_W-1:0];
            hold_full_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_holding_buffer_reg <= HOLD_RST;
            hold_full_reg <= 1'b0;
        end
        else
        begin
            tx_holding_buffer_reg <= tx_holding_buffer_next;
            hold_full_reg <= hold_full_next;
        end
    end

    // flag follows enable and buffer state only
    assign empty_cond = en && !hold_full_reg;
    // two-stage delay, so an early poll sees the old value
    // no bus term reaches the flag
    always_comb
    begin
        cond_d1_next = empty_cond;
        tx_buffer_empty_flag_next = cond_d1_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cond_d1_reg <= 1'b0;
            tx_buffer_empty_flag_reg <= 1'b0;
        end
        else
        begin
            cond_d1_reg <= cond_d1_next;
            tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_comb
    begin
        evt_next = evt_reg;
        if (wr && paddr == EVT_OFS)
            evt_next = evt_reg & ~pwdata[EVT_W-1:0];
        if (done)
            evt_next[EVT_DONE_BIT] = 1'b1;
        if (cond_d1_reg && !tx_buffer_empty_flag_reg)
            evt_next[EVT_EMPTY_BIT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_reg <= EVT_RST;
        else
            evt_reg <= evt_next;
    end

    // flag raises the request only through its enable
    assign irq = (|(evt_reg & mask_reg))
        || (tx_buffer_empty_flag_reg && tx_interrupt_enable_reg);

    atp_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy),
        .restart(load),
        .div(div_reg),
        .tick(tick)
    );

    atp_tx_shifter u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .load(load),
        .data(tx_holding_buffer_reg),
        .nine(ctrl_reg[CTRL_NINE_BIT]),
        .tick(tick),
        .line_raw(line_raw),
        .busy(busy),
        .done(done)
    );

    // whole frame inverted, asynchronous mode only
    always_comb
    begin
        if (tx_polarity_invert_reg && !sync_mode)
            tx_line_next = !line_raw;
        else
            tx_line_next = line_raw;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_line_reg <= 1'b1;
        else
            tx_line_reg <= tx_line_next;
    end
    assign tx_line = tx_line_reg;

    // read data registered in the setup cycle, valid in the access cycle
    always_comb
    begin
        prdata_next = 32'h00000000;
        if (rd_setup)
        begin
            unique case (paddr)
                CTRL_OFS: prdata_next[CTRL_W-1:0] = ctrl_reg;
                BAUD_CTRL_OFS: prdata_next[POL_BIT] = tx_polarity_invert_reg;
                DIV_OFS: prdata_next[DIV_W-1:0] = div_reg;
                HOLD_OFS: prdata_next[DATA_W-1:0] = tx_holding_buffer_reg;
                FLAG_OFS:
                begin
                    prdata_next[FLAG_BIT] = tx_buffer_empty_flag_reg;
                    prdata_next[BUSY_BIT] = busy;
                    prdata_next[FULL_BIT] = hold_full_reg;
                end
                IEN_OFS: prdata_next[IEN_BIT] = tx_interrupt_enable_reg;
                EVT_OFS: prdata_next[EVT_W-1:0] = evt_reg;
                MASK_OFS: prdata_next[EVT_W-1:0] = mask_reg;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h00000000;
        else
            prdata_reg <= prdata_next;
    end
    assign prdata = prdata_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence queued_s;
        $rose(hold_full_reg) ##1 hold_full_reg;
    endsequence

    sequence en_rise_s;
        $rose(en) && !hold_full_reg;
    endsequence

    pol_plain_a: assert property ((!tx_polarity_invert_reg || sync_mode)
        |=> tx_line == $past(line_raw))
        else $error("line not high-true with inversion off");
    pol_invert_a: assert property ((tx_polarity_invert_reg && !sync_mode)
        |=> tx_line == !$past(line_raw))
        else $error("line not inverted with inversion on");
    pol_sync_a: assert property ((sync_mode && $past(sync_mode))
        |-> tx_line)
        else $error("clocked mode line not idle high");
    flag_track_a: assert property (tx_buffer_empty_flag_reg
        == $past(empty_cond, FLAG_DELAY_CYC))
        else $error("flag does not follow buffer state");
    flag_queued_a: assert property (queued_s |=> !tx_buffer_empty_flag_reg)
        else $error("flag set while character queued");
    flag_late_a: assert property ((wr && paddr == HOLD_OFS && empty_cond)
        |-> ##2 tx_buffer_empty_flag_reg)
        else $error("flag cleared too early after write");
    flag_ro_a: assert property ((wr && paddr == FLAG_OFS && $stable(cond_d1_reg))
        |=> $stable(tx_buffer_empty_flag_reg))
        else $error("flag moved by software write");
    irq_gate_a: assert property ((!tx_interrupt_enable_reg && mask_reg == '0) |-> !irq)
        else $error("interrupt without enable");
    irq_flag_a: assert property (($past(empty_cond, FLAG_DELAY_CYC)
        && tx_interrupt_enable_reg) |-> irq)
        else $error("enabled flag gave no interrupt");
    start_bit_a: assert property (load |=> !line_raw)
        else $error("start bit not a space");
    stop_bit_a: assert property (done |-> line_raw ##1 line_raw)
        else $error("stop bit not a mark");
    hold_wait_a: assert property ((hold_full_reg && busy) |-> !load)
        else $error("buffer moved while shifter busy");
    hold_next_a: assert property ((hold_full_reg && done && tx_run) |=> (load || !tx_run))
        else $error("queued character did not follow stop bit");
    en_flag_a: assert property (en_rise_s ##1 !hold_full_reg
        |=> tx_buffer_empty_flag_reg)
        else $error("enable did not set flag");
endmodule : atp_tx_top

// ### testbench/atp_rx_model.sv
// behavioural far-end asynchronous receiver watching the transmit line
`timescale 1ns/1ps
module atp_rx_model #(
    parameter int BIT_CYC = 4
) (
    input wire logic pclk,
    input wire logic listen,
    input wire logic invert,
    input wire logic nine,
    input wire logic line,
    output logic [8:0] rx_data,
    output logic [7:0] rx_cnt,
    output logic rx_ferr
);
    logic [8:0] sh;
    initial
    begin
        rx_data = 9'h000;
        rx_cnt = 8'h00;
        rx_ferr = 1'b0;
    end
    // hunt for a start bit, then sample each bit near its middle
    always
    begin
        @(posedge pclk);
        if (listen && (line ^ invert) == 1'b0)
        begin
            repeat (BIT_CYC / 2) @(posedge pclk);
            sh = 9'h000;
            // first data bit is bit zero
            for (int i = 0; i < (nine ? 9 : 8); i++)
            begin
                repeat (BIT_CYC) @(posedge pclk);
                sh[i] = line ^ invert;
            end
            repeat (BIT_CYC) @(posedge pclk);
            if ((line ^ invert) !== 1'b1)
                rx_ferr = 1'b1;
            rx_data = sh;
            rx_cnt = rx_cnt + 8'h01;
        end
    end
endmodule : atp_rx_model

// ### testbench/tb_async_tx_polarity_and_flag.sv
// self-checking bench for the polarity and buffer-empty flag transmitter
`timescale 1ns/1ps
module tb_async_tx_polarity_and_flag;
    import atp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_line;
    logic irq;
    logic listen = 1'b0;
    logic invert = 1'b0;
    logic nine = 1'b0;
    logic [8:0] rx_data;
    logic [7:0] rx_cnt;
    logic rx_ferr;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int compares = 0;

    always #20 pclk = ~pclk;

    atp_tx_top i_atp_tx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_line(tx_line), .irq(irq));
    // divisor 3 gives four cycles a bit
    atp_rx_model #(.BIT_CYC(4)) i_atp_rx_model (.pclk(pclk), .listen(listen),
        .invert(invert), .nine(nine), .line(tx_line), .rx_data(rx_data), .rx_cnt(rx_cnt),
        .rx_ferr(rx_ferr));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic lvl(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : lvl

    // one transfer; bus stays selected, so idle must follow a run of calls
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken at the edge that samples pready high, pre-edge values
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask : rdc

    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle

    // bounded wait for the receiver to count a character
    task automatic rx_wait(input logic [7:0] cnt, input logic [8:0] exp);
        repeat (400) if (rx_cnt < cnt) @(posedge pclk);
        chk({24'h0, rx_cnt}, {24'h0, cnt});
        chk({23'h0, rx_data}, {23'h0, exp});
    endtask : rx_wait

    task automatic conclude();
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        lvl(tx_line, 1'b1);
        lvl(irq, 1'b0);
        rdc(BAUD_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        wr(FLAG_OFS, 32'h1);
        rdc(FLAG_OFS, 32'h1, 32'h0);
        wr(DIV_OFS, 32'h3);
        wr(CTRL_OFS, 32'h1);
        idle(3);
        rdc(FLAG_OFS, 32'h7, 32'h1);
        wr(FLAG_OFS, 32'h0);
        rdc(FLAG_OFS, 32'h1, 32'h1);
        idle(1);
        listen <= 1'b1;
        @(posedge pclk);
        // second character queues behind the first
        wr(HOLD_OFS, 32'hA5);
        idle(2);
        wr(HOLD_OFS, 32'h3C);
        rdc(FLAG_OFS, 32'h1, 32'h1);
        rdc(FLAG_OFS, 32'h7, 32'h6);
        idle(1);
        rx_wait(8'h01, 9'h0A5);
        rx_wait(8'h02, 9'h03C);
        idle(8);
        rdc(FLAG_OFS, 32'h7, 32'h1);
        // inversion flips idle level and whole frame
        listen <= 1'b0;
        wr(BAUD_CTRL_OFS, 32'h1);
        idle(3);
        lvl(tx_line, 1'b0);
        invert <= 1'b1;
        listen <= 1'b1;
        @(posedge pclk);
        wr(HOLD_OFS, 32'h81);
        idle(1);
        rx_wait(8'h03, 9'h081);
        idle(8);
        lvl(irq, 1'b0);
        // enable only while data remains, drop it with last char
        wr(IEN_OFS, 32'h1);
        idle(2);
        lvl(irq, 1'b1);
        wr(HOLD_OFS, 32'h55);
        wr(IEN_OFS, 32'h0);
        // earlier characters left done events behind; clear before unmasking
        wr(EVT_OFS, 32'h3);
        wr(MASK_OFS, 32'h1);
        idle(2);
        lvl(irq, 1'b0);
        rx_wait(8'h04, 9'h055);
        idle(8);
        lvl(irq, 1'b1);
        rdc(EVT_OFS, 32'h1, 32'h1);
        wr(EVT_OFS, 32'h3);
        idle(2);
        lvl(irq, 1'b0);
        wr(CTRL_OFS, 32'h5);
        nine <= 1'b1;
        wr(HOLD_OFS, 32'h1C3);
        idle(1);
        rx_wait(8'h05, 9'h1C3);
        idle(8);
        // clocked mode ignores the polarity bit
        listen <= 1'b0;
        wr(CTRL_OFS, 32'h3);
        idle(3);
        lvl(tx_line, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        lvl(err, 1'b1);
        idle(1);
        lvl(rx_ferr, 1'b0);
        conclude();
    end
endmodule : tb_async_tx_polarity_and_flag
